//--- dio_regs_chk.sv
`timescale 1ns/100ps
module dio_regs_chk #(
  parameter int NUM_INPUTS = 8,
  parameter int NUM_OUTPUTS = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  input wire logic [NUM_INPUTS-1:0] input_levels_i,
  input wire logic [NUM_OUTPUTS-1:0] output_levels_o,
  input wire logic input_power_on_o
);
  logic [5:0] fall_r;
  logic [15:0] hdr_r;
  // Cleared by chip select, like the slave's own bit counter
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fall_r <= 6'h00;
      hdr_r <= 16'h0000;
    end else begin
      if (fall_r != 6'h3f) begin
        fall_r <= fall_r + 6'h01;
      end
      if (fall_r < 6'h10) begin
        hdr_r <= {hdr_r[14:0], mosi_i};
      end
    end
  end
  oe_follows_cs_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) miso_oe_o == !cs_n_i)
    else $error("miso enable differs from chip select");
  idle_miso_low_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) cs_n_i |-> !miso_o)
    else $error("miso high while deselected");
  hdr_miso_low_a: assert property (@(negedge sclk_i) disable iff (cs_n_i)
    (fall_r < 6'h10 || fall_r > 6'h1f) |-> !miso_o) else $error("miso high outside data field");
  out_readback_a: assert property (@(negedge sclk_i) disable iff (cs_n_i)
    (hdr_r == 16'h0124 && fall_r[5:4] == 2'b01) |-> miso_o == (fall_r[3] && output_levels_o[~fall_r[2:0]]))
    else $error("output register read data wrong");
  power_readback_a: assert property (@(negedge sclk_i) disable iff (cs_n_i)
    (hdr_r == 16'h01c4 && fall_r[5:4] == 2'b01) |-> miso_o == (fall_r == 6'h1f && input_power_on_o))
    else $error("power enable read data wrong");
  other_page_a: assert property (@(negedge sclk_i) disable iff (cs_n_i)
    (hdr_r[15:12] != 4'h0 && !hdr_r[3] && fall_r[5:4] == 2'b01) |-> !miso_o)
    else $error("other page read not zero");
  reset_clear_a: assert property (@(posedge clk_i) !reset_n_i |=> output_levels_o == '0 && !input_power_on_o)
    else $error("registers not cleared by reset");
  idle_stable_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cs_n_i [*8] |-> $stable(output_levels_o) && $stable(input_power_on_o))
    else $error("register changed with no frame");
endmodule // dio_regs_chk
bind spi_paged_digital_io_regs dio_regs_chk #(.NUM_INPUTS(NUM_INPUTS), .NUM_OUTPUTS(NUM_OUTPUTS)) chk_u (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .mosi_i(mosi_i), .miso_o(miso_o),
  .miso_oe_o(miso_oe_o), .input_levels_i(input_levels_i), .output_levels_o(output_levels_o),
  .input_power_on_o(input_power_on_o));

//--- dio_spi_pkg.sv
package dio_spi_pkg;

  // Frame layout, counted in serial clock falling edges
  localparam int FRAME_BITS = 32;
  localparam int HDR_BITS = 16;
  localparam logic [5:0] HDR_DONE_CNT = 6'h10;
  localparam logic [5:0] LAST_BIT_CNT = 6'h1f;
  localparam logic [5:0] FRAME_END_CNT = 6'h20;

  // Field positions inside the 16-bit header
  localparam int HDR_PAGE_MSB = 15;
  localparam int HDR_PAGE_LSB = 12;
  localparam int HDR_ADDR_MSB = 11;
  localparam int HDR_ADDR_LSB = 4;
  localparam int HDR_RW_BIT = 3;
  localparam int HDR_WIDTH_BIT = 2;

  localparam logic RW_READ = 1'b0;
  localparam logic RW_WRITE = 1'b1;
  localparam logic WIDTH_BYTE = 1'b0;
  localparam logic WIDTH_WORD = 1'b1;

  // Unit pages
  localparam logic [3:0] PAGE_DIO = 4'h0;
  localparam logic [3:0] PAGE_AI = 4'h1;
  localparam logic [3:0] PAGE_CNT = 4'h2;

  // Page 0 register offsets
  localparam logic [7:0] ADDR_INPUT_LEVELS = 8'h10;
  localparam logic [7:0] ADDR_OUTPUT_LEVELS = 8'h12;
  localparam logic [7:0] ADDR_FILTER_TIME = 8'h18;
  localparam logic [7:0] ADDR_POWER_ENABLE = 8'h1c;

  // Field positions
  localparam int FILTER_CODE_LSB = 8;
  localparam int FILTER_CODE_MSB = 12;
  localparam int POWER_ON_BIT = 0;

  // Reset values
  localparam logic [7:0] OUTPUT_LEVELS_RST = 8'h00;
  localparam logic [4:0] FILTER_CODE_RST = 5'h00;
  localparam logic POWER_ON_RST = 1'b0;

  // Filter time base: code 1 is 250 ns, each code doubles it
  localparam int CLK_PERIOD_NS = 50;
  localparam int FILTER_BASE_NS = 250;
  localparam int FILTER_BASE_CYCLES = (FILTER_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] FILTER_CODE_MAX = 5'h14;
  localparam int FILTER_CNT_W = 20;

  // Word address match: both bytes of a register hit it
  function automatic logic addr_hits(input logic [7:0] addr, input logic [7:0] offset);
    addr_hits = (addr[7:1] == offset[7:1]);
  endfunction

endpackage

//--- input_filter.sv
`timescale 1ns/100ps
module input_filter #(
  parameter int WIDTH = 8,
  parameter int BASE_CYCLES = dio_spi_pkg::FILTER_BASE_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] code_i,
  input wire logic [WIDTH-1:0] raw_i,
  output logic [WIDTH-1:0] filt_o
);

  localparam int CW = dio_spi_pkg::FILTER_CNT_W;

  logic [15:0] pre_r;
  logic tick;
  logic bypass;
  logic [CW-1:0] thresh;
  logic [WIDTH-1:0] filt_r;

  assign tick = (pre_r == 16'(BASE_CYCLES - 1));
  // Reserved codes behave like code 0 rather than an undefined delay
  assign bypass = (code_i == 5'h00) || (code_i > dio_spi_pkg::FILTER_CODE_MAX);
  assign thresh = CW'(1) << (code_i - 5'h01);
  assign filt_o = bypass ? raw_i : filt_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || tick) begin
      pre_r <= 16'h0000;
    end else begin
      pre_r <= pre_r + 16'h0001;
    end
  end

  // One shared time base and threshold for all inputs
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic [CW-1:0] cnt_r;
      logic [CW-1:0] cnt_nxt;
      assign cnt_nxt = cnt_r + CW'(1);
      always_ff @(posedge clk_i) begin
        if (!reset_n_i || bypass) begin
          cnt_r <= '0;
          filt_r[g] <= raw_i[g];
        end else if (raw_i[g] == filt_r[g]) begin
          cnt_r <= '0;
        end else if (tick) begin
          if (cnt_nxt >= thresh) begin
            cnt_r <= '0;
            filt_r[g] <= raw_i[g];
          end else begin
            cnt_r <= cnt_nxt;
          end
        end
      end
    end
  endgenerate

endmodule // input_filter

//--- spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Clock runs only inside a frame; nbits below 32 aborts it
  task automatic frame(input logic [3:0] pg, input logic [7:0] a, input logic rw, input logic wd,
                       input logic [15:0] d, input int nbits, output logic [15:0] rdata);
    logic [31:0] word;
    word = {pg, a, rw, wd, 2'b00, d};
    rdata = 16'h0000;
    cs_n_o = 1'b0;
    #20;
    for (int i = 31; i > 31 - nbits; i--) begin
      sclk_o = 1'b1;
      mosi_o = word[i];
      #32;
      rdata = {rdata[14:0], miso_i};
      sclk_o = 1'b0;
      #32;
    end
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #400;
  endtask
endmodule // spi_host_model

//--- spi_paged_digital_io_regs.sv
// Contract
// - Slave samples the master data line on each serial clock falling edge.
// - Slave changes its output data on each serial clock rising edge.
// - Frame: 4-bit page, 8-bit address, R/W, width, two zero dummies, 16-bit data.
// - R/W bit zero means read, one means write.
// - Width bit zero means byte access, one means word access.
// - Byte data sits in low bits of data field, upper bits zero.
// - Page 0 is digital I/O, page 1 analog input, page 2 counter.
// - Page 0 address 10h reads eight input levels in bits 7..0, rest zero.
// - With nonzero filter time, input register reports filtered values.
// - Page 0 address 12h drives eight outputs from bits 7..0, reads back.
// - Page 0 address 18h holds filter code in bits 12..8, others zero.
// - One filter code applies to all inputs at once.
// - Code 0 disables filter; 1..20 double from 0.25 us; 21..31 reserved.
// - Page 0 address 1Ch bit 0 is input power enable, read back.
`timescale 1ns/100ps
module spi_paged_digital_io_regs #(
  parameter int NUM_INPUTS = 8,
  parameter int NUM_OUTPUTS = 8,
  parameter int FILTER_BASE_CYCLES = dio_spi_pkg::FILTER_BASE_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic [NUM_INPUTS-1:0] input_levels_i,
  output logic [NUM_OUTPUTS-1:0] output_levels_o,
  output logic input_power_on_o
);

  localparam int RB_W = NUM_INPUTS + NUM_OUTPUTS + 6;

  // Serial clock domain
  localparam int FRAME_W = dio_spi_pkg::FRAME_BITS;
  logic [5:0] bit_cnt_r;
  logic [FRAME_W-1:0] frame_r;
  logic [FRAME_W-1:0] frame_nxt;
  logic [15:0] tx_r;
  logic [RB_W-1:0] rb_s1_r;
  logic [RB_W-1:0] rb_s2_r;
  logic wr_tgl_r;
  logic [3:0] wr_page_r;
  logic [7:0] wr_addr_r;
  logic wr_width_r;
  logic [15:0] wr_data_r;

  logic [15:0] hdr;
  logic [15:0] last_hdr;
  logic [3:0] hdr_page;
  logic [7:0] hdr_addr;
  logic hdr_width;
  logic last_is_write;
  logic hdr_done;
  logic last_bit;
  logic unit_dio;
  logic unit_ai;
  logic unit_cnt;
  logic [NUM_INPUTS-1:0] rb_inputs;
  logic [NUM_OUTPUTS-1:0] rb_outputs;
  logic [4:0] rb_code;
  logic rb_power;
  logic [15:0] rd_reg;
  logic [15:0] rd_word;

  assign frame_nxt = {frame_r[FRAME_W-2:0], mosi_i};
  assign hdr = frame_r[dio_spi_pkg::HDR_BITS-1:0];
  assign last_hdr = frame_nxt[FRAME_W-1:FRAME_W-dio_spi_pkg::HDR_BITS];
  assign hdr_page = hdr[dio_spi_pkg::HDR_PAGE_MSB:dio_spi_pkg::HDR_PAGE_LSB];
  assign hdr_addr = hdr[dio_spi_pkg::HDR_ADDR_MSB:dio_spi_pkg::HDR_ADDR_LSB];
  assign hdr_width = hdr[dio_spi_pkg::HDR_WIDTH_BIT];
  assign last_is_write = (last_hdr[dio_spi_pkg::HDR_RW_BIT] == dio_spi_pkg::RW_WRITE);
  assign hdr_done = (bit_cnt_r == dio_spi_pkg::HDR_DONE_CNT);
  assign last_bit = (bit_cnt_r == dio_spi_pkg::LAST_BIT_CNT);

  // Other units are decoded only; their registers live elsewhere
  assign unit_dio = (hdr_page == dio_spi_pkg::PAGE_DIO);
  assign unit_ai = (hdr_page == dio_spi_pkg::PAGE_AI);
  assign unit_cnt = (hdr_page == dio_spi_pkg::PAGE_CNT);

  assign rb_inputs = rb_s2_r[NUM_INPUTS-1:0];
  assign rb_outputs = rb_s2_r[NUM_INPUTS+NUM_OUTPUTS-1:NUM_INPUTS];
  assign rb_code = rb_s2_r[NUM_INPUTS+NUM_OUTPUTS+4:NUM_INPUTS+NUM_OUTPUTS];
  assign rb_power = rb_s2_r[RB_W-1];

  always_comb begin
    rd_reg = 16'h0000;
    if (unit_dio && dio_spi_pkg::addr_hits(hdr_addr, dio_spi_pkg::ADDR_INPUT_LEVELS)) begin
      rd_reg[NUM_INPUTS-1:0] = rb_inputs;
    end else if (unit_dio && dio_spi_pkg::addr_hits(hdr_addr, dio_spi_pkg::ADDR_OUTPUT_LEVELS)) begin
      rd_reg[NUM_OUTPUTS-1:0] = rb_outputs;
    end else if (unit_dio && dio_spi_pkg::addr_hits(hdr_addr, dio_spi_pkg::ADDR_FILTER_TIME)) begin
      rd_reg[dio_spi_pkg::FILTER_CODE_MSB:dio_spi_pkg::FILTER_CODE_LSB] = rb_code;
    end else if (unit_dio && dio_spi_pkg::addr_hits(hdr_addr, dio_spi_pkg::ADDR_POWER_ENABLE)) begin
      rd_reg[dio_spi_pkg::POWER_ON_BIT] = rb_power;
    end
  end

  // Odd byte address picks the upper byte, then zero extends
  assign rd_word = (hdr_width == dio_spi_pkg::WIDTH_WORD) ? rd_reg :
                   (hdr_addr[0] ? {8'h00, rd_reg[15:8]} : {8'h00, rd_reg[7:0]});

  // Bit position ends with the frame: chip select clears it
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_r <= 6'h00;
      frame_r <= '0;
    end else begin
      frame_r <= frame_nxt;
      if (bit_cnt_r != dio_spi_pkg::FRAME_END_CNT) begin
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
    end
  end

  // Write request is taken on the last falling edge; aborted frames write nothing
  always_ff @(negedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_tgl_r <= 1'b0;
      wr_page_r <= 4'h0;
      wr_addr_r <= 8'h00;
      wr_width_r <= 1'b0;
      wr_data_r <= 16'h0000;
    end else if (!cs_n_i && last_bit && last_is_write) begin
      wr_tgl_r <= ~wr_tgl_r;
      wr_page_r <= last_hdr[dio_spi_pkg::HDR_PAGE_MSB:dio_spi_pkg::HDR_PAGE_LSB];
      wr_addr_r <= last_hdr[dio_spi_pkg::HDR_ADDR_MSB:dio_spi_pkg::HDR_ADDR_LSB];
      wr_width_r <= last_hdr[dio_spi_pkg::HDR_WIDTH_BIT];
      wr_data_r <= frame_nxt[15:0];
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      tx_r <= 16'h0000;
    end else if (hdr_done) begin
      tx_r <= rd_word;
    end else begin
      tx_r <= {tx_r[14:0], 1'b0};
    end
  end

  // Data field only; header and dummy time shows zero
  assign miso_o = (!cs_n_i && bit_cnt_r >= dio_spi_pkg::HDR_DONE_CNT) ? tx_r[15] : 1'b0;
  assign miso_oe_o = !cs_n_i;

  // System clock domain
  logic [NUM_INPUTS-1:0] in_s1_r;
  logic [NUM_INPUTS-1:0] in_s2_r;
  logic [NUM_INPUTS-1:0] filtered_inputs;
  logic wr_s1_r;
  logic wr_s2_r;
  logic wr_s3_r;
  logic wr_pulse;
  logic wr_dio;
  logic lo_we;
  logic hi_we;
  logic [15:0] wr_lanes;
  logic [NUM_OUTPUTS-1:0] out_levels_r;
  logic [NUM_OUTPUTS-1:0] out_levels_nxt;
  logic [4:0] filter_code_r;
  logic [4:0] filter_code_nxt;
  logic power_on_r;
  logic power_on_nxt;

  // Readback of slow state; settles well before the header is complete
  always_ff @(posedge sclk_i) begin
    rb_s1_r <= {power_on_r, filter_code_r, out_levels_r, filtered_inputs};
    rb_s2_r <= rb_s1_r;
  end

  always_ff @(posedge clk_i) begin
    in_s1_r <= input_levels_i;
    in_s2_r <= in_s1_r;
  end

  input_filter #(
    .WIDTH(NUM_INPUTS),
    .BASE_CYCLES(FILTER_BASE_CYCLES)
  ) u_filter (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .code_i(filter_code_r),
    .raw_i(in_s2_r),
    .filt_o(filtered_inputs)
  );

  // Write fields stay frozen from the toggle until the next write frame end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_s1_r <= 1'b0;
      wr_s2_r <= 1'b0;
      wr_s3_r <= 1'b0;
    end else begin
      wr_s1_r <= wr_tgl_r;
      wr_s2_r <= wr_s1_r;
      wr_s3_r <= wr_s2_r;
    end
  end

  assign wr_pulse = wr_s2_r ^ wr_s3_r;
  assign wr_dio = wr_pulse && (wr_page_r == dio_spi_pkg::PAGE_DIO);
  assign lo_we = wr_dio && (wr_width_r == dio_spi_pkg::WIDTH_WORD || !wr_addr_r[0]);
  assign hi_we = wr_dio && (wr_width_r == dio_spi_pkg::WIDTH_WORD || wr_addr_r[0]);
  assign wr_lanes = (wr_width_r == dio_spi_pkg::WIDTH_WORD) ? wr_data_r : {wr_data_r[7:0], wr_data_r[7:0]};

  // Input register is read only; other offsets fall through unchanged
  assign out_levels_nxt = (lo_we && dio_spi_pkg::addr_hits(wr_addr_r, dio_spi_pkg::ADDR_OUTPUT_LEVELS)) ?
                          wr_lanes[NUM_OUTPUTS-1:0] : out_levels_r;
  assign filter_code_nxt = (hi_we && dio_spi_pkg::addr_hits(wr_addr_r, dio_spi_pkg::ADDR_FILTER_TIME)) ?
                           wr_lanes[dio_spi_pkg::FILTER_CODE_MSB:dio_spi_pkg::FILTER_CODE_LSB] :
                           filter_code_r;
  assign power_on_nxt = (lo_we && dio_spi_pkg::addr_hits(wr_addr_r, dio_spi_pkg::ADDR_POWER_ENABLE)) ?
                        wr_lanes[dio_spi_pkg::POWER_ON_BIT] : power_on_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      out_levels_r <= dio_spi_pkg::OUTPUT_LEVELS_RST;
      filter_code_r <= dio_spi_pkg::FILTER_CODE_RST;
      power_on_r <= dio_spi_pkg::POWER_ON_RST;
    end else begin
      out_levels_r <= out_levels_nxt;
      filter_code_r <= filter_code_nxt;
      power_on_r <= power_on_nxt;
    end
  end

  assign output_levels_o = out_levels_r;
  assign input_power_on_o = power_on_r;

  // Analog and counter pages answer zero here
  logic unused_units;
  assign unused_units = unit_ai | unit_cnt;

endmodule // spi_paged_digital_io_regs

//--- spi_paged_digital_io_regs_test.sv
`timescale 1ns/100ps
module spi_paged_digital_io_regs_test;
  logic clk, reset_n, sclk, cs_n, mosi, miso, miso_oe, pwr;
  logic [7:0] in_lv;
  logic [7:0] out_lv;
  logic [15:0] rd;
  int failures = 0;
  int cmp_count = 0;
  spi_paged_digital_io_regs #(.FILTER_BASE_CYCLES(1)) dut_u (.clk_i(clk), .reset_n_i(reset_n), .sclk_i(sclk),
    .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .input_levels_i(in_lv),
    .output_levels_o(out_lv), .input_power_on_o(pwr));
  spi_host_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] pg, input logic [7:0] a, input logic wd, input logic [15:0] d);
    host_u.frame(pg, a, 1'b1, wd, d, 32, rd);
  endtask
  task automatic rdc(input string name, input logic [3:0] pg, input logic [7:0] a, input logic wd,
                     input logic [15:0] exp);
    host_u.frame(pg, a, 1'b0, wd, 16'h0000, 32, rd);
    check(name, exp, rd);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    tally_and_finish;
  end
  initial begin
    reset_n = 1'b0;
    in_lv = 8'h5a;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    #7;
    rdc("out reset", 4'h0, 8'h12, 1'b1, 16'h0000);
    rdc("filter reset", 4'h0, 8'h18, 1'b1, 16'h0000);
    rdc("power reset", 4'h0, 8'h1c, 1'b1, 16'h0000);
    rdc("inputs", 4'h0, 8'h10, 1'b1, 16'h005a);
    wr(4'h0, 8'h12, 1'b1, 16'hffaa);
    check("out pins", 16'h00aa, {8'h00, out_lv});
    rdc("out word", 4'h0, 8'h12, 1'b1, 16'h00aa);
    wr(4'h0, 8'h12, 1'b0, 16'h0055);
    check("out byte pins", 16'h0055, {8'h00, out_lv});
    rdc("out low byte", 4'h0, 8'h12, 1'b0, 16'h0055);
    rdc("out high byte", 4'h0, 8'h13, 1'b0, 16'h0000);
    wr(4'h0, 8'h10, 1'b1, 16'hffff);
    wr(4'h1, 8'h12, 1'b1, 16'h0033);
    wr(4'h2, 8'h12, 1'b1, 16'h0033);
    wr(4'h0, 8'h14, 1'b1, 16'hffff);
    host_u.frame(4'h0, 8'h12, 1'b1, 1'b1, 16'h00ff, 20, rd);
    check("out kept", 16'h0055, {8'h00, out_lv});
    rdc("page one", 4'h1, 8'h12, 1'b1, 16'h0000);
    rdc("unused", 4'h0, 8'h14, 1'b1, 16'h0000);
    rdc("inputs ro", 4'h0, 8'h10, 1'b1, 16'h005a);
    wr(4'h0, 8'h18, 1'b1, 16'hffff);
    rdc("filter code", 4'h0, 8'h18, 1'b1, 16'h1f00);
    wr(4'h0, 8'h18, 1'b1, 16'h0300);
    // One clock glitch on all pins is shorter than code 3 needs
    @(negedge clk);
    in_lv = 8'ha5;
    @(negedge clk);
    in_lv = 8'h5a;
    rdc("glitch held", 4'h0, 8'h10, 1'b1, 16'h005a);
    in_lv = 8'ha5;
    repeat (20) @(negedge clk);
    rdc("filtered", 4'h0, 8'h10, 1'b1, 16'h00a5);
    wr(4'h0, 8'h1c, 1'b1, 16'hffff);
    check("power pin", 16'h0001, {15'h0000, pwr});
    rdc("power", 4'h0, 8'h1c, 1'b1, 16'h0001);
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    check("out after reset", 16'h0000, {7'h00, pwr, out_lv});
    tally_and_finish;
  end
endmodule // spi_paged_digital_io_regs_test
